// file: hw/etho_pkg.sv
// package: register map, field layout, digit limits and state encoding for event trigger and homing logic
`default_nettype none
package etho_pkg;
	// -----------------------------------------------------------------
	// register addresses (word addresses of the parameter space)
	// -----------------------------------------------------------------
	localparam logic [15:0] ADDR_EVENT_RISE = 16'h05c4; // event_rise_path_map
	localparam logic [15:0] ADDR_EVENT_FALL = 16'h05c6; // event_fall_path_map
	localparam logic [15:0] ADDR_HOME_DEF = 16'h0600; // homing_definition_word
	localparam logic [15:0] ADDR_HOME_COORD = 16'h0602; // home_coordinate_value
	localparam logic [15:0] ADDR_STATUS = 16'h0604; // block status, read only
	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [15:0] RST_EVENT_MAP = 16'h0000;
	localparam logic [31:0] RST_HOME_DEF = 32'h0000_0000;
	localparam logic [31:0] RST_HOME_COORD = 32'h0000_0000;
	// -----------------------------------------------------------------
	// field positions of the homing definition word
	// -----------------------------------------------------------------
	localparam int HD_BOOT_LSB = 28;
	localparam int HD_DLY_LSB = 20;
	localparam int HD_SECOND_DECEL_INDEX_LSB = 16;
	localparam int HD_FIRST_DECEL_INDEX_LSB = 12;
	localparam int HD_ACC_LSB = 8;
	localparam int HD_PATH_LSB = 0;
	localparam logic [7:0] HD_PATH_MAX = 8'h3f; // highest legal path number
	// -----------------------------------------------------------------
	// event map digit limits and path base
	// -----------------------------------------------------------------
	localparam logic [3:0] EV_DIGIT_MAX = 4'hd; // digits above d are clipped
	localparam logic [5:0] EV_PATH_BASE = 6'h32; // path = 50 + digit
	localparam int EV_COUNT = 4;
	// -----------------------------------------------------------------
	// homing sequencer states, gray coded along the usual path
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_SEEK = 3'h1,
		HS_DECEL = 3'h3,
		HS_DELAY = 3'h2,
		HS_DONE = 3'h6
	} etho_home_st_t;
endpackage
`default_nettype wire

// file: hw/etho_event_edge.sv
// event input synchroniser and edge to path-request mapper for one event line
`default_nettype none
module etho_event_edge
	import etho_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// raw event pin and maps
	input wire logic event_pin,
	input wire logic [3:0] rise_digit,
	input wire logic [3:0] fall_digit,
	// request out
	output logic req_valid,
	output logic [5:0] req_path
);
	// -----------------------------------------------------------------
	// synchroniser and previous sample
	// -----------------------------------------------------------------
	logic sync1_q, sync2_q, prev_q; // sync1 read only by sync2
	logic sync1_d, sync2_d, prev_d;
	logic valid_q, valid_d;
	logic [5:0] path_q, path_d;
	logic rise, fall;

	// digit to path number: zero launches nothing, else 50 + digit
	function automatic logic [5:0] digit_path(input logic [3:0] dg);
		logic [3:0] cl;
		cl = (dg > EV_DIGIT_MAX) ? EV_DIGIT_MAX : dg;
		digit_path = EV_PATH_BASE + {2'h0, cl};
	endfunction

	// next-state logic; each edge seen once against prior sample
	always_comb begin
		sync1_d = event_pin;
		sync2_d = sync1_q;
		prev_d = sync2_q;
		rise = sync2_q & ~prev_q;
		fall = ~sync2_q & prev_q;
		valid_d = 1'b0;
		path_d = path_q;
		if (rise && rise_digit != 4'h0) begin
			valid_d = 1'b1;
			path_d = digit_path(rise_digit);
		end else if (fall && fall_digit != 4'h0) begin
			valid_d = 1'b1;
			path_d = digit_path(fall_digit);
		end
	end

	// registers only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			valid_q <= 1'b0;
			path_q <= 6'h00;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q <= prev_d;
			valid_q <= valid_d;
			path_q <= path_d;
		end
	end

	assign req_valid = valid_q;
	assign req_path = path_q;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	property p_rise_launch;
		@(posedge clk) disable iff (!rstn)
		(sync2_q && !prev_q && rise_digit != 4'h0) |=> (req_valid && req_path >= 6'd51);
	endproperty
	a_rise_launch: assert property (p_rise_launch) else $error("rise edge missed");
	property p_zero_quiet;
		@(posedge clk) disable iff (!rstn)
		(sync2_q && !prev_q && rise_digit == 4'h0) |=> !req_valid;
	endproperty
	a_zero_quiet: assert property (p_zero_quiet) else $error("zero digit launched");
	property p_fall_launch;
		@(posedge clk) disable iff (!rstn)
		(!sync2_q && prev_q && fall_digit != 4'h0)
		|=> (req_valid && req_path == digit_path($past(fall_digit)));
	endproperty
	a_fall_launch: assert property (p_fall_launch) else $error("fall edge missed");
	property p_fall_zero;
		@(posedge clk) disable iff (!rstn)
		(!sync2_q && prev_q && fall_digit == 4'h0) |=> !req_valid;
	endproperty
	a_fall_zero: assert property (p_fall_zero) else $error("zero fall digit launched");
	property p_single;
		@(posedge clk) disable iff (!rstn)
		// a quick pin pulse may legally give two requests in a row, one per edge,
		// so the check is that no request appears without a fresh edge behind it
		(sync2_q == prev_q) |=> !req_valid;
	endproperty
	a_single: assert property (p_single) else $error("request without an edge");
	c_rise: cover property (@(posedge clk) disable iff (!rstn) req_valid && sync2_q);
endmodule
`default_nettype wire

// file: hw/etho_top.sv
// top: event trigger path mapping, homing definition decode and home sequencer
// -----------------------------------------------------------------
// Summary of operation
// - rising map: four hex digits, each 0..d
// - zero rising digit launches no path
// - rising edge launches path 50 plus digit
// - separate falling map; zero digit launches nothing
// - falling edge launches path 50 plus digit
// - homing word fields at fixed bit positions
// - path zero: stop after homing, no launch
// - path 1..63 launched after homing completes
// - accel field indexes sixteen ramp settings
// - first decel field indexes same ramps
// - delay field indexes sixteen delay settings
// - boot field read only in the first cycle after reset, while it still holds 0, so no power-up homing
// - home reference seen: decelerate to stop
// - homing done loads home coordinate
// -----------------------------------------------------------------
`default_nettype none
module etho_top
	import etho_pkg::*;
#(
	parameter int NUM_EVENTS = EV_COUNT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// parameter access port (keypad or communication)
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [15:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// external event inputs, pins
	input wire logic [NUM_EVENTS-1:0] event_in,
	// homing interface to the motion engine
	input wire logic home_start,
	input wire logic home_ref_pin,
	input wire logic motion_stopped,
	input wire logic delay_expired,
	output logic home_seek,
	output logic home_decel,
	output logic home_delay_run,
	output logic [3:0] accel_index,
	output logic [3:0] first_decel_index,
	output logic [3:0] second_decel_index,
	output logic [3:0] delay_index,
	output logic home_done,
	output logic [31:0] position_load_value,
	output logic position_load,
	// path launch requests
	output logic path_launch,
	output logic [5:0] path_number
);
	// -----------------------------------------------------------------
	// configuration registers
	// -----------------------------------------------------------------
	logic [15:0] rise_map_q, rise_map_d; // event_rise_path_map
	logic [15:0] fall_map_q, fall_map_d; // event_fall_path_map
	logic [31:0] home_def_q, home_def_d; // homing_definition_word
	logic [31:0] home_coord_q, home_coord_d; // home_coordinate_value
	logic [31:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	etho_home_st_t st_q, st_d; // homing sequencer state, also read back as status

	// clip each hex digit to the legal range 0..d
	function automatic logic [15:0] clip_map(input logic [15:0] w);
		logic [15:0] r;
		r = w;
		for (int i = 0; i < 4; i++) begin
			if (w[i*4 +: 4] > EV_DIGIT_MAX)
				r[i*4 +: 4] = EV_DIGIT_MAX;
		end
		clip_map = r;
	endfunction

	// write decode and read mux
	always_comb begin
		rise_map_d = rise_map_q;
		fall_map_d = fall_map_q;
		home_def_d = home_def_q;
		home_coord_d = home_coord_q;
		rdata_d = rdata_q;
		rvalid_d = cfg_rd;
		if (cfg_wr) begin
			case (cfg_addr)
				ADDR_EVENT_RISE: rise_map_d = clip_map(cfg_wdata[15:0]);
				ADDR_EVENT_FALL: fall_map_d = clip_map(cfg_wdata[15:0]);
				ADDR_HOME_DEF: home_def_d = cfg_wdata;
				ADDR_HOME_COORD: home_coord_d = cfg_wdata;
				default: ; // unmapped writes are dropped
			endcase
		end
		if (cfg_rd) begin
			case (cfg_addr)
				ADDR_EVENT_RISE: rdata_d = {16'h0000, rise_map_q};
				ADDR_EVENT_FALL: rdata_d = {16'h0000, fall_map_q};
				ADDR_HOME_DEF: rdata_d = home_def_q;
				ADDR_HOME_COORD: rdata_d = home_coord_q;
				ADDR_STATUS: rdata_d = {29'h0, st_q};
				default: rdata_d = 32'h0000_0000; // unmapped reads as zero
			endcase
		end
	end

	// -----------------------------------------------------------------
	// homing definition decode
	// -----------------------------------------------------------------
	logic boot_en;
	logic [7:0] home_path;
	assign boot_en = (home_def_q[HD_BOOT_LSB +: 4] == 4'h1);
	assign home_path = home_def_q[HD_PATH_LSB +: 8];
	assign accel_index = home_def_q[HD_ACC_LSB +: 4];
	assign first_decel_index = home_def_q[HD_FIRST_DECEL_INDEX_LSB +: 4];
	assign second_decel_index = home_def_q[HD_SECOND_DECEL_INDEX_LSB +: 4];
	assign delay_index = home_def_q[HD_DLY_LSB +: 4];

	// -----------------------------------------------------------------
	// home reference synchroniser and boot request
	// -----------------------------------------------------------------
	logic ref1_q, ref2_q; // ref1 read only by ref2
	logic boot_pend_q, boot_pend_d; // power-up homing still owed
	logic done_q, done_d;
	logic load_q, load_d;
	logic [31:0] load_val_q, load_val_d;
	logic hlaunch_q, hlaunch_d;
	logic [5:0] hpath_q, hpath_d;

	// homing sequencer next state
	always_comb begin
		st_d = st_q;
		boot_pend_d = boot_pend_q;
		done_d = 1'b0;
		load_d = 1'b0;
		load_val_d = load_val_q;
		hlaunch_d = 1'b0;
		hpath_d = hpath_q;
		case (st_q)
			HS_IDLE: begin
				// boot request checked once, in the first cycle out of reset, then dropped
				if (home_start || (boot_pend_q && boot_en)) begin
					st_d = HS_SEEK;
				end
				boot_pend_d = 1'b0;
			end
			HS_SEEK: begin
				if (ref2_q)
					st_d = HS_DECEL;
			end
			HS_DECEL: begin
				if (motion_stopped)
					st_d = HS_DELAY;
			end
			HS_DELAY: begin
				if (delay_expired)
					st_d = HS_DONE;
			end
			HS_DONE: begin
				done_d = 1'b1;
				load_d = 1'b1;
				load_val_d = home_coord_q;
				if (home_path != 8'h00 && home_path <= HD_PATH_MAX) begin
					hlaunch_d = 1'b1;
					hpath_d = home_path[5:0];
				end // path zero just stops
				st_d = HS_IDLE;
			end
			default: st_d = HS_IDLE;
		endcase
	end

	assign home_seek = (st_q == HS_SEEK);
	assign home_decel = (st_q == HS_DECEL);
	assign home_delay_run = (st_q == HS_DELAY);

	// -----------------------------------------------------------------
	// event edge mappers, one per input
	// -----------------------------------------------------------------
	logic [NUM_EVENTS-1:0] ev_valid;
	logic [5:0] ev_path [NUM_EVENTS];
	for (genvar g = 0; g < NUM_EVENTS; g++) begin : g_ev
		etho_event_edge u_edge (
			.clk(clk),
			.rstn(rstn),
			.event_pin(event_in[g]),
			.rise_digit(rise_map_q[g*4 +: 4]),
			.fall_digit(fall_map_q[g*4 +: 4]),
			.req_valid(ev_valid[g]),
			.req_path(ev_path[g])
		);
	end

	// -----------------------------------------------------------------
	// launch arbiter: homing first, then lowest event number
	// -----------------------------------------------------------------
	logic launch_q, launch_d;
	logic [5:0] lpath_q, lpath_d;
	always_comb begin
		launch_d = 1'b0;
		lpath_d = lpath_q;
		if (hlaunch_q) begin
			launch_d = 1'b1;
			lpath_d = hpath_q;
		end else begin
			for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
				if (ev_valid[i]) begin
					launch_d = 1'b1;
					lpath_d = ev_path[i];
				end
			end
		end
	end

	// registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rise_map_q <= RST_EVENT_MAP;
			fall_map_q <= RST_EVENT_MAP;
			home_def_q <= RST_HOME_DEF;
			home_coord_q <= RST_HOME_COORD;
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
			ref1_q <= 1'b0;
			ref2_q <= 1'b0;
			boot_pend_q <= 1'b1;
			st_q <= HS_IDLE;
			done_q <= 1'b0;
			load_q <= 1'b0;
			load_val_q <= 32'h0000_0000;
			hlaunch_q <= 1'b0;
			hpath_q <= 6'h00;
			launch_q <= 1'b0;
			lpath_q <= 6'h00;
		end else begin
			rise_map_q <= rise_map_d;
			fall_map_q <= fall_map_d;
			home_def_q <= home_def_d;
			home_coord_q <= home_coord_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			ref1_q <= home_ref_pin;
			ref2_q <= ref1_q;
			boot_pend_q <= boot_pend_d;
			st_q <= st_d;
			done_q <= done_d;
			load_q <= load_d;
			load_val_q <= load_val_d;
			hlaunch_q <= hlaunch_d;
			hpath_q <= hpath_d;
			launch_q <= launch_d;
			lpath_q <= lpath_d;
		end
	end

	assign cfg_rdata = rdata_q;
	assign cfg_rvalid = rvalid_q;
	assign home_done = done_q;
	assign position_load = load_q;
	assign position_load_value = load_val_q;
	assign path_launch = launch_q;
	assign path_number = lpath_q;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	property p_map_range;
		@(posedge clk) disable iff (!rstn)
		(rise_map_q[3:0] <= EV_DIGIT_MAX) && (rise_map_q[15:12] <= EV_DIGIT_MAX);
	endproperty
	a_map_range: assert property (p_map_range) else $error("rise digit out of range");
	property p_done_load;
		@(posedge clk) disable iff (!rstn)
		(st_q == HS_DONE) |=> (position_load && position_load_value == $past(home_coord_q));
	endproperty
	a_done_load: assert property (p_done_load) else $error("home coordinate not loaded");
	property p_path_zero;
		@(posedge clk) disable iff (!rstn)
		(st_q == HS_DONE && home_path == 8'h00) |=> !hlaunch_q;
	endproperty
	a_path_zero: assert property (p_path_zero) else $error("path zero launched");
	property p_path_auto;
		@(posedge clk) disable iff (!rstn)
		(st_q == HS_DONE && home_path != 8'h00 && home_path <= HD_PATH_MAX)
		|=> ##1 (path_launch && path_number == $past(home_path[5:0], 2));
	endproperty
	a_path_auto: assert property (p_path_auto) else $error("homing path not launched");
	property p_ref_decel;
		@(posedge clk) disable iff (!rstn)
		(st_q == HS_SEEK && ref2_q) |=> home_decel;
	endproperty
	a_ref_decel: assert property (p_ref_decel) else $error("no decel on home reference");
	property p_boot;
		@(posedge clk) disable iff (!rstn)
		(st_q == HS_IDLE && boot_pend_q && !boot_en && !home_start) |=> (st_q == HS_IDLE);
	endproperty
	a_boot: assert property (p_boot) else $error("boot homing while disabled");
	property p_acc;
		@(posedge clk) disable iff (!rstn)
		accel_index == home_def_q[11:8] && delay_index == home_def_q[23:20];
	endproperty
	a_acc: assert property (p_acc) else $error("index field misplaced");
	c_home: cover property (@(posedge clk) disable iff (!rstn) st_q == HS_DONE);
	c_ev: cover property (@(posedge clk) disable iff (!rstn) path_launch && !hlaunch_q);
	c_boot: cover property (@(posedge clk) disable iff (!rstn) boot_pend_q && boot_en);
endmodule
`default_nettype wire

// file: sim/etho_far_side.sv
// far side model: event pins, home sensor and motion engine around the block
`default_nettype none
module etho_far_side (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// bench control: wanted event levels and slow answers
	input wire logic [3:0] ev_level,
	input wire logic slow,
	// homing phase seen from the block
	input wire logic home_seek,
	input wire logic home_decel,
	input wire logic home_delay_run,
	// lines into the block
	output logic [3:0] event_in,
	output logic home_ref_pin,
	output logic motion_stopped,
	output logic delay_expired
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt; // cycles spent in the current phase
	int lag; // answer delay, short or long
	logic [2:0] ph_q; // phase of the previous cycle
	// --------------------------------------------------------------
	// drive on the falling edge, away from the block's sampling edge
	// --------------------------------------------------------------
	always @(negedge clk or negedge rstn) begin
		lag = slow ? 12 : 2;
		if (!rstn) begin
			cnt <= 0;
			ph_q <= 3'h0;
			event_in <= 4'h0;
			home_ref_pin <= 1'b0;
			motion_stopped <= 1'b0;
			delay_expired <= 1'b0;
		end else begin
			event_in <= ev_level;
			ph_q <= {home_seek, home_decel, home_delay_run};
			// restart the count whenever the phase changes
			cnt <= (ph_q != {home_seek, home_decel, home_delay_run}) ? 0 : cnt + 1;
			// sensor passes by briefly, it is not a level to rely on
			home_ref_pin <= home_seek && cnt >= lag && cnt < lag + 4;
			// motor stays stopped through the delay phase
			motion_stopped <= (home_decel && cnt >= lag) || home_delay_run;
			delay_expired <= home_delay_run && cnt >= lag;
		end
	end
endmodule
`default_nettype wire

// file: sim/etho_top_tb_top.sv
// testbench: register access, event triggers and homing runs of etho_top
`default_nettype none
module etho_top_tb_top
	import etho_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// --------------------------------------------------------------
	// signals
	// --------------------------------------------------------------
	logic clk, rstn, cfg_wr, cfg_rd, cfg_rvalid, home_start, slow;
	logic [15:0] cfg_addr;
	logic [31:0] cfg_wdata, cfg_rdata, position_load_value;
	logic [3:0] event_in, ev_level, accel_index, first_decel_index;
	logic [3:0] second_decel_index, delay_index;
	logic home_ref_pin, motion_stopped, delay_expired, home_seek, home_decel;
	logic home_delay_run, home_done, position_load, path_launch;
	logic [5:0] path_number;
	int miscompares, total_checks;
	localparam logic [15:0] RISE_MAP = 16'hd071; // digits 1, 7, 0, d
	localparam logic [15:0] FALL_MAP = 16'h240d; // digits d, 0, 4, 2
	// --------------------------------------------------------------
	// design and far side
	// --------------------------------------------------------------
	etho_top etho_top_inst (.clk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
		.cfg_rdata, .cfg_rvalid, .event_in, .home_start, .home_ref_pin, .motion_stopped,
		.delay_expired, .home_seek, .home_decel, .home_delay_run, .accel_index,
		.first_decel_index, .second_decel_index, .delay_index, .home_done,
		.position_load_value, .position_load, .path_launch, .path_number);
	etho_far_side etho_far_side_inst (.clk, .rstn, .ev_level, .slow, .home_seek,
		.home_decel, .home_delay_run, .event_in, .home_ref_pin, .motion_stopped,
		.delay_expired);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic wrap_up();
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// a write is taken at the rising edge between two falling edges
	task automatic cfg_write(input logic [15:0] a, input logic [31:0] d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	task automatic cfg_check(input string what, input logic [15:0] a, input logic [31:0] exp);
		int n;
		n = 0;
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk);
		cfg_rd = 1'b0;
		// bounded wait for the answer pulse
		while (cfg_rvalid !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		if (n == 4) begin
			miscompares++;
			$display("Error read answer expected 1 seen 0");
			wrap_up();
		end
		chk(what, exp, cfg_rdata);
	endtask
	// watch outputs for a fixed window, counting launches and homing results
	task automatic watch(input int cyc, output int n, output logic [5:0] num,
		output logic dn, output logic dc, output logic [31:0] ld);
		n = 0;
		num = 6'h00;
		dn = 1'b0;
		dc = 1'b0;
		ld = 32'h0;
		repeat (cyc) begin
			@(negedge clk);
			if (path_launch === 1'b1) begin
				n++;
				num = path_number;
			end
			if (home_decel === 1'b1) dc = 1'b1;
			if (home_done === 1'b1) dn = 1'b1;
			if (position_load === 1'b1) ld = position_load_value;
		end
	endtask
	// one homing run; the expected launch follows the path field alone
	task automatic home_run(input logic [31:0] def, input logic [31:0] coord);
		int n;
		logic [5:0] num;
		logic dn, dc;
		logic [31:0] ld;
		cfg_write(ADDR_HOME_DEF, def);
		cfg_write(ADDR_HOME_COORD, coord);
		cfg_check("homing word", ADDR_HOME_DEF, def);
		chk("accel index", def[11:8], accel_index);
		chk("first decel index", def[15:12], first_decel_index);
		chk("second decel index", def[19:16], second_decel_index);
		chk("delay index", def[23:20], delay_index);
		@(negedge clk);
		home_start = 1'b1;
		@(negedge clk);
		home_start = 1'b0;
		watch(150, n, num, dn, dc, ld);
		chk("decel phase", 1, dc);
		chk("home done", 1, dn);
		chk("home coordinate", coord, ld);
		chk("home launch count", (def[7:0] != 8'h00) ? 1 : 0, n);
		if (def[7:0] != 8'h00) chk("home path", def[5:0], num);
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		int n;
		logic [5:0] num;
		logic dn, dc;
		logic [31:0] ld;
		logic [3:0] dg;
		{cfg_wr, cfg_rd, home_start, slow} = 4'h0;
		cfg_addr = 16'h0000;
		cfg_wdata = 32'h0;
		ev_level = 4'h0;
		rstn = 1'b0;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		// reset values and an unmapped place
		cfg_check("rise map reset", ADDR_EVENT_RISE, 32'h0);
		cfg_check("fall map reset", ADDR_EVENT_FALL, 32'h0);
		cfg_check("homing word reset", ADDR_HOME_DEF, 32'h0);
		cfg_check("coordinate reset", ADDR_HOME_COORD, 32'h0);
		cfg_check("status idle", ADDR_STATUS, 32'h0);
		cfg_write(16'h05c8, 32'h0000_5555);
		cfg_check("unmapped read", 16'h05c8, 32'h0);
		cfg_write(ADDR_EVENT_RISE, {16'h0, RISE_MAP});
		cfg_write(ADDR_EVENT_FALL, {16'h0, FALL_MAP});
		cfg_check("rise map", ADDR_EVENT_RISE, {16'h0, RISE_MAP});
		cfg_check("fall map", ADDR_EVENT_FALL, {16'h0, FALL_MAP});
		// each event line up then down; one edge gives at most one launch
		for (int i = 0; i < 4; i++) begin
			ev_level[i] = 1'b1;
			dg = RISE_MAP[i*4 +: 4];
			watch(16, n, num, dn, dc, ld);
			chk("rise launch count", (dg != 4'h0) ? 1 : 0, n);
			if (dg != 4'h0) chk("rise path", EV_PATH_BASE + 6'(dg), num);
			ev_level[i] = 1'b0;
			dg = FALL_MAP[i*4 +: 4];
			watch(16, n, num, dn, dc, ld);
			chk("fall launch count", (dg != 4'h0) ? 1 : 0, n);
			if (dg != 4'h0) chk("fall path", EV_PATH_BASE + 6'(dg), num);
		end
		// homing: prompt far side, then slow, path field at both ends
		home_run(32'h1054_322a, 32'hffff_fff0);
		slow = 1'b1;
		home_run(32'h00ff_ff00, 32'h0000_1234);
		home_run(32'h0000_f13f, 32'h8000_0000);
		wrap_up();
	end
	// guard against a hang anywhere in the sequence
	initial begin
		#200000;
		miscompares++;
		$display("Error run time expected end seen limit");
		wrap_up();
	end
endmodule
`default_nettype wire
